// [common/audio_fifo_consts.svh]
`ifndef AUDIO_FIFO_CONSTS_SVH
`define AUDIO_FIFO_CONSTS_SVH
// register byte offsets
`define OFF_GCTL 8'h00
`define OFF_TX_EN 8'h04
`define OFF_RX_EN 8'h08
`define OFF_WLEN 8'h0c
`define OFF_TX_LEFT 8'h10
`define OFF_TX_RIGHT 8'h14
`define OFF_RX_LEFT 8'h18
`define OFF_RX_RIGHT 8'h1c
`define OFF_STATUS 8'h20
// word length codes
`define WL_16 2'h0
`define WL_24 2'h1
`define WL_32 2'h2
// fifo levels
`define FIFO_FULL 4'h8
`define FIFO_HALF 4'h4
// status field positions
`define STS_TX_LSB 5'h00
`define STS_RX_LSB 5'h05
// reset values
`define RST_WORD 32'h0000_0000
`endif

// [common/audio_fifo_pkg.sv]
package audio_fifo_pkg;
   typedef struct packed {
      logic [31:0] left;
      logic [31:0] right;
   } pair_t;
   typedef struct packed {
      logic full;
      logic half;
      logic empty;
      logic ovf;
      logic unf;
   } fifo_flags_t;
   typedef struct packed {
      logic rx_data;
      logic lrck;
      logic sclk;
   } link_in_t;
   typedef enum logic [1:0] {
      TX_OFF = 2'b00,
      TX_FETCH = 2'b01,
      TX_WAIT = 2'b10,
      TX_RUN = 2'b11
   } tx_state_t;
   typedef enum logic [1:0] {
      RX_OFF = 2'b00,
      RX_SYNC = 2'b01,
      RX_LEFT = 2'b10,
      RX_RIGHT = 2'b11
   } rx_state_t;
endpackage

// [src/audio_channel_fifo.sv]
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
// Operation
// - enable fetches pair, shifts left then right
// - only low 16/24 bits shifted out
// - fetch next pair on right load; wrap
// - controller disable zeroes fifo and pointers
// - channel disable aborts shift, fifo untouched
// - empty at enable: resend holding registers
// - empty at fetch: underflow, pointer stays
// - tx underflow clears on pair or controller disable
// - five flags: unf, ovf, empty, half, full
// - receiver waits for next left word start
// - left then right shift into data registers
// - received pairs fill successive locations
// - location freed after both ports read
// - empty read: last data, underflow flag
// - full receive: drop pair, mark last good
// - overflow flag at mark, cleared reading it
// - received words right justified, zero padded
// - registers reachable only over apb
// - tx location committed after both words
// - write while full: drop, overflow flag
`include "audio_fifo_consts.svh"
module audio_channel_fifo
   import audio_fifo_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sclk_in,
   input wire logic lrck_in,
   input wire logic rx_serial_in,
   output logic tx_serial_out
);
   function automatic logic [31:0] low_bits(input logic [31:0] d, input logic [1:0] wl);
      if (wl == `WL_16)
         low_bits = {16'h0000, d[15:0]};
      else if (wl == `WL_24)
         low_bits = {8'h00, d[23:0]};
      else
         low_bits = d;
   endfunction
   function automatic logic [31:0] msb_align(input logic [31:0] d, input logic [1:0] wl);
      if (wl == `WL_16)
         msb_align = {d[15:0], 16'h0000};
      else if (wl == `WL_24)
         msb_align = {d[23:0], 8'h00};
      else
         msb_align = d;
   endfunction

   // link synchroniser, three stages
   link_in_t s1_r, s2_r, s3_r, lvl_r, lvl_d_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= {rx_serial_in, lrck_in, sclk_in};
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvl_r <= '0;
         lvl_d_r <= '0;
      end else begin
         lvl_r <= (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
         lvl_d_r <= lvl_r;
      end
   end
   logic sclk_rise, sclk_fall, lrck_rise, lrck_fall;
   assign sclk_rise = lvl_r.sclk & ~lvl_d_r.sclk;
   assign sclk_fall = ~lvl_r.sclk & lvl_d_r.sclk;
   assign lrck_rise = lvl_r.lrck & ~lvl_d_r.lrck;
   assign lrck_fall = ~lvl_r.lrck & lvl_d_r.lrck;

   // apb slave, one wait state
   logic hit, wr, rd;
   logic pready_r, pslverr_r;
   logic [31:0] prdata_r;
   assign hit = psel & penable & ~pready_r;
   assign wr = hit & pwrite;
   assign rd = hit & ~pwrite;
   logic gctl_r, tx_en_r, rx_en_r;
   logic [1:0] wlen_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gctl_r <= 1'b0;
         tx_en_r <= 1'b0;
         rx_en_r <= 1'b0;
         wlen_r <= `WL_16;
      end else if (wr) begin
         if (paddr == `OFF_GCTL)
            gctl_r <= pwdata[0];
         if (paddr == `OFF_TX_EN)
            tx_en_r <= pwdata[0];
         if (paddr == `OFF_RX_EN)
            rx_en_r <= pwdata[0];
         if (paddr == `OFF_WLEN)
            wlen_r <= pwdata[1:0];
      end
   end
   logic mapped;
   always_comb begin
      unique case (paddr)
         `OFF_GCTL, `OFF_TX_EN, `OFF_RX_EN, `OFF_WLEN, `OFF_TX_LEFT, `OFF_TX_RIGHT,
         `OFF_RX_LEFT, `OFF_RX_RIGHT, `OFF_STATUS:
            mapped = 1'b1;
         default:
            mapped = 1'b0;
      endcase
   end

   // transmit fifo
   pair_t tx_mem_r [8];
   logic [2:0] tx_wp_r, tx_rp_r;
   logic [3:0] tx_cnt_r;
   logic [31:0] tx_lstage_r;
   logic tx_lpend_r, tx_push, tx_pop, tx_unf_r, tx_ovf_r;
   tx_state_t tx_state_r;
   fifo_flags_t tx_flags, rx_flags;
   assign tx_push = wr & (paddr == `OFF_TX_RIGHT) & tx_lpend_r & (tx_cnt_r != `FIFO_FULL);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_lpend_r <= 1'b0;
         tx_lstage_r <= `RST_WORD;
      end else if (!gctl_r) begin
         tx_lpend_r <= 1'b0;
      end else if (wr && paddr == `OFF_TX_LEFT) begin
         tx_lstage_r <= pwdata;
         tx_lpend_r <= 1'b1;
      end else if (wr && paddr == `OFF_TX_RIGHT) begin
         tx_lpend_r <= 1'b0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 8; i++)
            tx_mem_r[i] <= '0;
         tx_wp_r <= 3'h0;
      end else if (!gctl_r) begin
         for (int i = 0; i < 8; i++)
            tx_mem_r[i] <= '0;
         tx_wp_r <= 3'h0;
      end else if (tx_push) begin
         tx_mem_r[tx_wp_r] <= '{left: tx_lstage_r, right: pwdata};
         tx_wp_r <= tx_wp_r + 3'h1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_rp_r <= 3'h0;
         tx_cnt_r <= 4'h0;
      end else if (!gctl_r) begin
         tx_rp_r <= 3'h0;
         tx_cnt_r <= 4'h0;
      end else begin
         if (tx_pop)
            tx_rp_r <= tx_rp_r + 3'h1;
         tx_cnt_r <= tx_cnt_r + {3'h0, tx_push} - {3'h0, tx_pop};
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_unf_r <= 1'b0;
         tx_ovf_r <= 1'b0;
      end else if (!gctl_r) begin
         tx_unf_r <= 1'b0;
         tx_ovf_r <= 1'b0;
      end else begin
         if (tx_state_r == TX_RUN && lrck_rise && tx_cnt_r == 4'h0)
            tx_unf_r <= 1'b1;
         else if (tx_push)
            tx_unf_r <= 1'b0;
         if (wr && paddr == `OFF_TX_RIGHT && tx_lpend_r && tx_cnt_r == `FIFO_FULL)
            tx_ovf_r <= 1'b1;
         else if (wr && paddr == `OFF_STATUS && pwdata[`STS_TX_LSB + 5'h1])
            tx_ovf_r <= 1'b0;
      end
   end

   // transmit channel
   logic [31:0] tx_lhold_r, tx_rhold_r, tx_sh_r;
   logic tx_out_r;
   assign tx_pop = gctl_r & tx_en_r & (tx_cnt_r != 4'h0) &
      ((tx_state_r == TX_FETCH) | ((tx_state_r == TX_RUN) & lrck_rise));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_state_r <= TX_OFF;
      end else if (!(gctl_r && tx_en_r)) begin
         tx_state_r <= TX_OFF;
      end else begin
         unique case (tx_state_r)
            TX_OFF:
               tx_state_r <= TX_FETCH;
            TX_FETCH:
               tx_state_r <= TX_WAIT;
            TX_WAIT:
               if (lrck_fall)
                  tx_state_r <= TX_RUN;
            TX_RUN:
               tx_state_r <= TX_RUN;
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_lhold_r <= `RST_WORD;
         tx_rhold_r <= `RST_WORD;
      end else if (tx_pop) begin
         tx_lhold_r <= tx_mem_r[tx_rp_r].left;
         tx_rhold_r <= tx_mem_r[tx_rp_r].right;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_sh_r <= `RST_WORD;
         tx_out_r <= 1'b0;
      end else if (tx_state_r == TX_OFF || tx_state_r == TX_FETCH) begin
         tx_sh_r <= `RST_WORD;
         tx_out_r <= 1'b0;
      end else if (lrck_fall) begin
         tx_sh_r <= msb_align(tx_lhold_r, wlen_r);
         tx_out_r <= tx_lhold_r[msb_pos(wlen_r)];
      end else if (lrck_rise && tx_state_r == TX_RUN) begin
         tx_sh_r <= msb_align(tx_rhold_r, wlen_r);
         tx_out_r <= tx_rhold_r[msb_pos(wlen_r)];
      end else if (sclk_fall && tx_state_r == TX_RUN) begin
         tx_sh_r <= {tx_sh_r[30:0], 1'b0};
         tx_out_r <= tx_sh_r[30];
      end
   end
   function automatic logic [4:0] msb_pos(input logic [1:0] wl);
      if (wl == `WL_16)
         msb_pos = 5'd15;
      else if (wl == `WL_24)
         msb_pos = 5'd23;
      else
         msb_pos = 5'd31;
   endfunction

   // receive channel
   rx_state_t rx_state_r;
   logic [31:0] rx_sh_r, rx_ldata_r, rx_rdata_r;
   logic [5:0] rx_bits_r, rx_need;
   logic rx_done;
   assign rx_need = (wlen_r == `WL_16) ? 6'd16 : (wlen_r == `WL_24) ? 6'd24 : 6'd32;
   assign rx_done = (rx_state_r == RX_RIGHT) & lrck_fall;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_state_r <= RX_OFF;
      end else if (!(gctl_r && rx_en_r)) begin
         rx_state_r <= RX_OFF;
      end else begin
         unique case (rx_state_r)
            RX_OFF:
               rx_state_r <= RX_SYNC;
            RX_SYNC:
               if (lrck_fall)
                  rx_state_r <= RX_LEFT;
            RX_LEFT:
               if (lrck_rise)
                  rx_state_r <= RX_RIGHT;
            RX_RIGHT:
               if (lrck_fall)
                  rx_state_r <= RX_LEFT;
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_sh_r <= `RST_WORD;
         rx_bits_r <= 6'h00;
         rx_ldata_r <= `RST_WORD;
         rx_rdata_r <= `RST_WORD;
      end else if (lrck_rise || lrck_fall) begin
         rx_sh_r <= `RST_WORD;
         rx_bits_r <= 6'h00;
         if (rx_state_r == RX_LEFT && lrck_rise)
            rx_ldata_r <= low_bits(rx_sh_r, wlen_r);
         if (rx_done)
            rx_rdata_r <= low_bits(rx_sh_r, wlen_r);
      end else if (sclk_rise && rx_state_r[1] && rx_bits_r < rx_need) begin
         rx_sh_r <= {rx_sh_r[30:0], lvl_r.rx_data};
         rx_bits_r <= rx_bits_r + 6'h01;
      end
   end
   // pair pushed the cycle after the right word completes
   logic rx_push_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         rx_push_r <= 1'b0;
      else
         rx_push_r <= rx_done & gctl_r;
   end

   // receive fifo
   pair_t rx_mem_r [8];
   logic [2:0] rx_wp_r, rx_rp_r, rx_mark_r;
   logic [3:0] rx_cnt_r;
   logic rx_push, rx_pop, rx_lrd_r, rx_rrd_r, rx_empty_rd;
   logic rx_unf_r, rx_ovf_pend_r, rx_ovf_r;
   logic [31:0] rx_last_l_r, rx_last_r_r;
   assign rx_push = rx_push_r & (rx_cnt_r != `FIFO_FULL);
   assign rx_empty_rd = rd & (rx_cnt_r == 4'h0) &
      ((paddr == `OFF_RX_LEFT) | (paddr == `OFF_RX_RIGHT));
   assign rx_pop = rd & (rx_cnt_r != 4'h0) &
      (((paddr == `OFF_RX_LEFT) & rx_rrd_r) | ((paddr == `OFF_RX_RIGHT) & rx_lrd_r));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 8; i++)
            rx_mem_r[i] <= '0;
         rx_wp_r <= 3'h0;
      end else if (!gctl_r) begin
         for (int i = 0; i < 8; i++)
            rx_mem_r[i] <= '0;
         rx_wp_r <= 3'h0;
      end else if (rx_push) begin
         rx_mem_r[rx_wp_r] <= '{left: rx_ldata_r, right: rx_rdata_r};
         rx_wp_r <= rx_wp_r + 3'h1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_rp_r <= 3'h0;
         rx_cnt_r <= 4'h0;
         rx_lrd_r <= 1'b0;
         rx_rrd_r <= 1'b0;
      end else if (!gctl_r) begin
         rx_rp_r <= 3'h0;
         rx_cnt_r <= 4'h0;
         rx_lrd_r <= 1'b0;
         rx_rrd_r <= 1'b0;
      end else begin
         rx_cnt_r <= rx_cnt_r + {3'h0, rx_push} - {3'h0, rx_pop};
         if (rx_pop) begin
            rx_rp_r <= rx_rp_r + 3'h1;
            rx_lrd_r <= 1'b0;
            rx_rrd_r <= 1'b0;
         end else if (rd && rx_cnt_r != 4'h0) begin
            if (paddr == `OFF_RX_LEFT)
               rx_lrd_r <= 1'b1;
            if (paddr == `OFF_RX_RIGHT)
               rx_rrd_r <= 1'b1;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_last_l_r <= `RST_WORD;
         rx_last_r_r <= `RST_WORD;
      end else if (!gctl_r) begin
         rx_last_l_r <= `RST_WORD;
         rx_last_r_r <= `RST_WORD;
      end else if (rd && rx_cnt_r != 4'h0) begin
         if (paddr == `OFF_RX_LEFT)
            rx_last_l_r <= rx_mem_r[rx_rp_r].left;
         if (paddr == `OFF_RX_RIGHT)
            rx_last_r_r <= rx_mem_r[rx_rp_r].right;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_unf_r <= 1'b0;
         rx_ovf_pend_r <= 1'b0;
         rx_mark_r <= 3'h0;
         rx_ovf_r <= 1'b0;
      end else if (!gctl_r) begin
         rx_unf_r <= 1'b0;
         rx_ovf_pend_r <= 1'b0;
         rx_ovf_r <= 1'b0;
      end else begin
         if (rx_empty_rd)
            rx_unf_r <= 1'b1;
         else if (wr && paddr == `OFF_STATUS && pwdata[`STS_RX_LSB])
            rx_unf_r <= 1'b0;
         if (rx_push_r && rx_cnt_r == `FIFO_FULL && !rx_ovf_pend_r) begin
            rx_ovf_pend_r <= 1'b1;
            rx_mark_r <= rx_wp_r - 3'h1;
         end else if (rx_pop && rx_ovf_pend_r && rx_rp_r == rx_mark_r) begin
            rx_ovf_pend_r <= 1'b0;
         end
         rx_ovf_r <= rx_ovf_pend_r && rx_rp_r == rx_mark_r && !rx_pop;
      end
   end

   // flags and read data
   always_comb begin
      tx_flags.full = tx_cnt_r == `FIFO_FULL;
      tx_flags.half = tx_cnt_r <= `FIFO_HALF;
      tx_flags.empty = tx_cnt_r == 4'h0;
      tx_flags.ovf = tx_ovf_r;
      tx_flags.unf = tx_unf_r;
      rx_flags.full = rx_cnt_r == `FIFO_FULL;
      rx_flags.half = rx_cnt_r <= `FIFO_HALF;
      rx_flags.empty = rx_cnt_r == 4'h0;
      rx_flags.ovf = rx_ovf_r;
      rx_flags.unf = rx_unf_r;
   end
   logic [31:0] rdata;
   always_comb begin
      rdata = `RST_WORD;
      unique case (paddr)
         `OFF_GCTL: rdata = {31'h0, gctl_r};
         `OFF_TX_EN: rdata = {31'h0, tx_en_r};
         `OFF_RX_EN: rdata = {31'h0, rx_en_r};
         `OFF_WLEN: rdata = {30'h0, wlen_r};
         `OFF_RX_LEFT:
            rdata = (rx_cnt_r == 4'h0) ? rx_last_l_r : rx_mem_r[rx_rp_r].left;
         `OFF_RX_RIGHT:
            rdata = (rx_cnt_r == 4'h0) ? rx_last_r_r : rx_mem_r[rx_rp_r].right;
         `OFF_STATUS: rdata = {22'h0, rx_flags, tx_flags};
         default: rdata = `RST_WORD;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= `RST_WORD;
      end else begin
         pready_r <= hit;
         pslverr_r <= hit & ~mapped;
         if (rd)
            prdata_r <= rdata;
      end
   end
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign tx_serial_out = tx_out_r;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_full_right_wr;
      wr && paddr == `OFF_TX_RIGHT && tx_lpend_r && tx_cnt_r == `FIFO_FULL && !tx_pop;
   endsequence
   sequence s_tx_held_off;
      gctl_r && !tx_en_r ##1 gctl_r && !tx_en_r;
   endsequence
   sequence s_left_only_rd;
      rd && paddr == `OFF_RX_LEFT && rx_cnt_r != 4'h0 && !rx_rrd_r;
   endsequence
   AST_TX_DROP: assert property (s_full_right_wr |=> tx_cnt_r == `FIFO_FULL && tx_ovf_r
      && $stable(tx_wp_r)) else $error("tx write while full not dropped");
   AST_FLUSH: assert property (!gctl_r |=> tx_cnt_r == 4'h0 && rx_cnt_r == 4'h0
      && tx_rp_r == 3'h0 && rx_wp_r == 3'h0) else $error("fifo not flushed");
   AST_TX_ABORT: assert property (s_tx_held_off |=> tx_state_r == TX_OFF
      && !tx_serial_out && $stable(tx_rp_r)) else $error("tx disable not aborting");
   AST_TX_UNF: assert property (gctl_r && tx_en_r && tx_state_r == TX_RUN && lrck_rise
      && tx_cnt_r == 4'h0 |=> tx_unf_r && $stable(tx_rp_r)) else $error("tx underflow missed");
   AST_RX_WAIT: assert property (rx_state_r == RX_SYNC && !lrck_fall |=>
      rx_state_r != RX_LEFT && rx_state_r != RX_RIGHT) else $error("rx started early");
   AST_RX_HALF: assert property (s_left_only_rd |=> $stable(rx_rp_r)
      && rx_cnt_r >= $past(rx_cnt_r)) else $error("rx location freed early");
   AST_RX_UNF: assert property (rx_empty_rd |=> rx_unf_r && $stable(rx_rp_r)
      && pready) else $error("rx underflow missed");
   AST_RX_OVF: assert property (rx_push_r && rx_cnt_r == `FIFO_FULL |=>
      $stable(rx_wp_r) && rx_ovf_pend_r) else $error("rx overflow not dropped");
   AST_TX_PAIR: assert property (gctl_r && wr && paddr == `OFF_TX_LEFT && !tx_pop |=>
      $stable(tx_cnt_r) && tx_lpend_r) else $error("tx committed on half pair");
   AST_APB: assert property (hit |=> pready ##1 !pready) else $error("apb answer wrong");
endmodule

// [test/audio_codec_model.sv]
`timescale 1ns/1ps
module audio_codec_model
   import audio_fifo_pkg::*;
(
   output logic sclk,
   output logic lrck,
   output logic sdata,
   input wire logic tx_bit,
   output logic [15:0] cap_left,
   output logic [15:0] cap_right
);
   localparam logic [15:0] LEFT_WORD = 16'h5ac3;
   localparam logic [15:0] RIGHT_WORD = 16'h3ca5;
   logic [15:0] sh;
   // frames run back to back, data and word clock change at bit clock falling
   initial begin
      sclk = 1'h0;
      lrck = 1'h0;
      sdata = 1'h0;
      sh = 16'h0000;
      cap_left = 16'h0000;
      cap_right = 16'h0000;
      #1000;
      forever begin
         for (int i = 0; i < 32; i++) begin
            // sample previous slot just before moving on
            sh = {sh[14:0], tx_bit};
            if (i == 0) begin
               cap_right = sh;
            end
            if (i == 16) begin
               cap_left = sh;
            end
            lrck = (i >= 16);
            sdata = (i < 16) ? LEFT_WORD[15 - i] : RIGHT_WORD[31 - i];
            #100 sclk = 1'h1;
            #100 sclk = 1'h0;
         end
      end
   end
endmodule

// [test/tb_stereo_serial_audio_channel_fifo.sv]
`timescale 1ns/1ps
`include "audio_fifo_consts.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_stereo_serial_audio_channel_fifo
   import audio_fifo_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd_data;
   logic sclk_in, lrck_in, rx_serial_in, tx_serial_out, rd_err;
   logic [15:0] cap_left, cap_right;
   int miscompares, cmp_count;

   audio_channel_fifo dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sclk_in(sclk_in), .lrck_in(lrck_in), .rx_serial_in(rx_serial_in),
      .tx_serial_out(tx_serial_out));
   audio_codec_model codec (.sclk(sclk_in), .lrck(lrck_in), .sdata(rx_serial_in),
      .tx_bit(tx_serial_out), .cap_left(cap_left), .cap_right(cap_right));

   always #12.5 pclk = ~pclk;

   task finish_test;
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // one apb transfer, entered just after a rising edge
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      if (n >= 50) miscompares++;
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask
   task rd(input logic [7:0] a);
      apb(1'h0, a, 32'h0000_0000);
   endtask

   task test_reset;
      rd(`OFF_STATUS);
      `CHK("status_rst", 32'h0000_018c, rd_data)
      `CHK("mapped_err", 1'h0, rd_err)
      rd(8'h40);
      `CHK("unmapped_err", 1'h1, rd_err)
      `CHK("unmapped_data", 32'h0000_0000, rd_data)
   endtask

   task test_tx;
      wr(`OFF_GCTL, 32'h0000_0001);
      wr(`OFF_WLEN, {30'h0, `WL_16});
      wr(`OFF_TX_LEFT, 32'hffff_1234);
      rd(`OFF_STATUS);
      `CHK("tx_half_pair", 32'h0000_018c, rd_data)
      wr(`OFF_TX_RIGHT, 32'hffff_abcd);
      rd(`OFF_STATUS);
      `CHK("tx_one_pair", 32'h0000_0188, rd_data)
      wr(`OFF_TX_EN, 32'h0000_0001);
      repeat (1100) @(posedge pclk);
      `CHK("tx_left_word", 16'h1234, cap_left)
      `CHK("tx_right_word", 16'habcd, cap_right)
      rd(`OFF_STATUS);
      `CHK("tx_underflow", 32'h0000_018d, rd_data)
      wr(`OFF_TX_LEFT, 32'h0000_0001);
      wr(`OFF_TX_RIGHT, 32'h0000_0002);
      rd(`OFF_STATUS);
      `CHK("tx_unf_clear", 1'h0, rd_data[0])
      repeat (800) @(posedge pclk);
      `CHK("tx_next_left", 16'h0001, cap_left)
      `CHK("tx_next_right", 16'h0002, cap_right)
      wr(`OFF_TX_EN, 32'h0000_0000);
   endtask

   task test_tx_full;
      for (int i = 0; i < 9; i++) begin
         wr(`OFF_TX_LEFT, 32'h0000_0010 + i);
         wr(`OFF_TX_RIGHT, 32'h0000_0020 + i);
      end
      rd(`OFF_STATUS);
      `CHK("tx_full_ovf", 32'h0000_0192, rd_data)
      wr(`OFF_STATUS, 32'h0000_0002);
      rd(`OFF_STATUS);
      `CHK("tx_ovf_clear", 32'h0000_0190, rd_data)
      wr(`OFF_GCTL, 32'h0000_0000);
      rd(`OFF_STATUS);
      `CHK("ctrl_flush", 32'h0000_018c, rd_data)
   endtask

   task test_rx;
      wr(`OFF_GCTL, 32'h0000_0001);
      wr(`OFF_WLEN, {30'h0, `WL_16});
      wr(`OFF_RX_EN, 32'h0000_0001);
      repeat (2900) @(posedge pclk);
      wr(`OFF_RX_EN, 32'h0000_0000);
      rd(`OFF_STATUS);
      `CHK("rx_full", 32'h0000_020c, rd_data)
      for (int i = 0; i < 8; i++) begin
         rd(`OFF_RX_LEFT);
         `CHK("rx_left", 32'h0000_5ac3, rd_data)
         if (i == 0) begin
            rd(`OFF_STATUS);
            `CHK("rx_half_read", 32'h0000_020c, rd_data)
         end
         rd(`OFF_RX_RIGHT);
         `CHK("rx_right", 32'h0000_3ca5, rd_data)
         if (i == 6) begin
            rd(`OFF_STATUS);
            `CHK("rx_ovf_mark", 32'h0000_014c, rd_data)
         end
      end
      rd(`OFF_STATUS);
      `CHK("rx_drained", 32'h0000_018c, rd_data)
      rd(`OFF_RX_LEFT);
      `CHK("rx_empty_read", 32'h0000_5ac3, rd_data)
      rd(`OFF_STATUS);
      `CHK("rx_underflow", 32'h0000_01ac, rd_data)
   endtask

   // 24-bit words: codec sees the top 16 of the low 24 bits
   task test_tx24;
      wr(`OFF_WLEN, {30'h0, `WL_24});
      wr(`OFF_TX_LEFT, 32'hff12_3456);
      wr(`OFF_TX_RIGHT, 32'hee65_4321);
      wr(`OFF_TX_EN, 32'h0000_0001);
      repeat (1100) @(posedge pclk);
      `CHK("tx24_left", 16'h1234, cap_left)
      `CHK("tx24_right", 16'h6543, cap_right)
      wr(`OFF_TX_EN, 32'h0000_0000);
   endtask

   initial begin
      pclk = 1'h0;
      presetn = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      miscompares = 0;
      cmp_count = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      test_reset();
      test_tx();
      test_tx_full();
      test_rx();
      test_tx24();
      finish_test();
   end

   initial begin
      #400000;
      miscompares++;
      finish_test();
   end
endmodule
